// [verilog/htc_pkg.sv]
/*
 Constants, register map and carrier types of the 16-bit timer/counter.
 Assumes a single 25 MHz mclk domain and an APB master with 32-bit data.
*/
package htc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int CTRL_W = 8;
	localparam int IRQ_W = 3;

	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PRESCALE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_TOP = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CMP = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h20;

	localparam int CTRL_RSTEN_BIT = 8;
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_CMP_BIT = 1;
	localparam int IRQ_CAP_BIT = 2;

	typedef enum logic [1:0] {
		MODE_WDT = 2'b00,
		MODE_CTC = 2'b01,
		MODE_FPWM = 2'b10,
		MODE_PFC = 2'b11
	} htc_mode_t;

	localparam logic [1:0] CLK_SYS = 2'h0;
	localparam logic [1:0] CLK_PIN_RISE = 2'h1;
	localparam logic [1:0] CLK_PIN_FALL = 2'h2;
	localparam logic [1:0] CLK_STOP = 2'h3;

	// Bit 0 upward: mode, clksel, enable, cap_en, invert, down
	typedef struct packed {
		logic down;
		logic invert;
		logic cap_en;
		logic enable;
		logic [1:0] clksel;
		htc_mode_t mode;
	} htc_ctrl_t;

	localparam htc_ctrl_t CTRL_RST = 8'h00;
	localparam logic [CNT_W-1:0] PRESCALE_RST = 16'h0000;
	localparam logic [CNT_W-1:0] TOP_RST = 16'hffff;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_OVF_ONLY = 3'h1;

	// Stand-alone preload: watchdog, mclk source, running, full range
	localparam htc_ctrl_t PRE_CTRL = 8'h10;
	localparam logic [CNT_W-1:0] PRE_PRESCALE = 16'h0000;
	localparam logic [CNT_W-1:0] PRE_TOP = 16'hffff;
	localparam logic [CNT_W-1:0] PRE_CMP = 16'h8000;
	localparam logic RSTEN_PRE = 1'b1;

	localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;

endpackage : htc_pkg

// [verilog/htc_sync.sv]
/*
 Three-stage pin synchroniser with a debounced level and edge pulses.
 Assumes the pin is asynchronous to mclk and slower than a quarter of it.
*/
`timescale 1ns/100ps
module htc_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;
	wire agree = (s2 == s3);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			level <= INIT;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			if (agree) begin
				level <= s3;
			end
			rise <= agree & s3 & ~level;
			fall <= agree & ~s3 & level;
		end
	end

endmodule : htc_sync

// [verilog/htc_timer.sv]
/*
 Timer/counter top: APB register slave, prescaler, counter, compare,
 capture and interrupt outputs.
 Assumes one mclk domain; all pins arrive asynchronous and are synchronised.
*/
`timescale 1ns/100ps
module htc_timer
	import htc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_clock_in,
	input wire logic timer_reset_low_input,
	input wire logic capture_trigger_in,
	input wire logic standalone_mode,
	output logic timer_irq_out,
	output logic wake_irq_out,
	output logic compare_wave_out
);

	function automatic logic [CNT_W-1:0] f_step(input logic [CNT_W-1:0] v, input logic down);
		f_step = down ? v - 16'h0001 : v + 16'h0001;
	endfunction : f_step

	function automatic logic [DATA_W-1:0] f_ext16(input logic [CNT_W-1:0] v);
		f_ext16 = {16'h0000, v};
	endfunction : f_ext16

	function automatic logic [DATA_W-1:0] f_ext3(input logic [IRQ_W-1:0] v);
		f_ext3 = {29'h00000000, v};
	endfunction : f_ext3

	// Pin synchronisers
	logic clk_rise;
	logic clk_fall;
	logic rstn_level;
	logic cap_rise;
	logic sa_level;

	htc_sync #(.INIT(1'b0)) u_sync_clk (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(timer_clock_in),
		.level(),
		.rise(clk_rise),
		.fall(clk_fall)
	);

	htc_sync #(.INIT(1'b1)) u_sync_rstn (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(timer_reset_low_input),
		.level(rstn_level),
		.rise(),
		.fall()
	);

	htc_sync #(.INIT(1'b0)) u_sync_cap (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(capture_trigger_in),
		.level(),
		.rise(cap_rise),
		.fall()
	);

	htc_sync #(.INIT(1'b0)) u_sync_sa (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(standalone_mode),
		.level(sa_level),
		.rise(),
		.fall()
	);

	// Registers
	htc_ctrl_t ctrl_reg;
	logic [CNT_W-1:0] prescale_reg;
	logic [CNT_W-1:0] top_reg;
	logic [CNT_W-1:0] cmp_reg;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_status;
	logic reset_pin_enable_bit;
	logic [CNT_W-1:0] count_value;
	logic [CNT_W-1:0] capture_holding_reg;
	logic [CNT_W-1:0] top_act;
	logic [CNT_W-1:0] cmp_act;
	logic [CNT_W-1:0] psc_cnt;
	logic dir_down;

	// Stand-alone swaps in the preloaded control set
	wire htc_ctrl_t ctrl_act = sa_level ? PRE_CTRL : ctrl_reg;
	wire [CNT_W-1:0] prescale_act = sa_level ? PRE_PRESCALE : prescale_reg;
	wire [CNT_W-1:0] top_src = sa_level ? PRE_TOP : top_reg;
	wire [CNT_W-1:0] cmp_src = sa_level ? PRE_CMP : cmp_reg;

	// Reset pin cannot be disabled: the enable bit is never writable
	wire pin_clear = reset_pin_enable_bit & ~rstn_level;

	// APB decode; bus writes are ignored in stand-alone, reads are still answered
	wire apb_setup = psel & ~penable;
	wire apb_access = psel & penable & pready;
	wire apb_wr = apb_access & pwrite & ~sa_level;
	wire sel_ctrl = (paddr == ADDR_CTRL);
	wire sel_psc = (paddr == ADDR_PRESCALE);
	wire sel_top = (paddr == ADDR_TOP);
	wire sel_cmp = (paddr == ADDR_CMP);
	wire sel_count = (paddr == ADDR_COUNT);
	wire sel_cap = (paddr == ADDR_CAPTURE);
	wire sel_stat = (paddr == ADDR_IRQ_STATUS);
	wire sel_en = (paddr == ADDR_IRQ_ENABLE);
	wire sel_clr = (paddr == ADDR_IRQ_CLEAR);
	wire addr_hit = sel_ctrl | sel_psc | sel_top | sel_cmp | sel_count | sel_cap | sel_stat | sel_en | sel_clr;
	wire wr_count = apb_wr & sel_count;
	wire wr_clr = apb_wr & sel_clr;
	wire wr_ctrl = apb_wr & sel_ctrl;
	wire wr_psc = apb_wr & sel_psc;
	wire wr_top = apb_wr & sel_top;
	wire wr_cmp = apb_wr & sel_cmp;
	wire wr_en = apb_wr & sel_en;

	wire [DATA_W-1:0] rd_mux =
		sel_ctrl ? {23'h000000, reset_pin_enable_bit, ctrl_act} :
		sel_psc ? f_ext16(prescale_act) :
		sel_top ? f_ext16(top_src) :
		sel_cmp ? f_ext16(cmp_src) :
		sel_count ? f_ext16(count_value) :
		sel_cap ? f_ext16(capture_holding_reg) :
		sel_stat ? f_ext3(irq_status) :
		sel_en ? f_ext3(irq_en) :
		32'h00000000;

	// Clock source and prescaler
	wire src_evt = ctrl_act.enable & (
		(ctrl_act.clksel == CLK_SYS) |
		((ctrl_act.clksel == CLK_PIN_RISE) & clk_rise) |
		((ctrl_act.clksel == CLK_PIN_FALL) & clk_fall));
	wire psc_done = (psc_cnt >= prescale_act);
	wire tick = src_evt & psc_done;
	wire [CNT_W-1:0] next_psc = pin_clear ? COUNT_ZERO :
		(src_evt ? (psc_done ? COUNT_ZERO : f_step(psc_cnt, 1'b0)) : psc_cnt);

	// Counter sequencing per mode
	logic [CNT_W-1:0] step_count;
	logic step_dir;
	logic period_end;
	logic ovf_cond;

	always_comb begin
		step_count = count_value;
		step_dir = dir_down;
		period_end = 1'b0;
		ovf_cond = 1'b0;
		unique case (ctrl_act.mode)
			MODE_WDT: begin
				step_count = f_step(count_value, ctrl_act.down);
				ovf_cond = ctrl_act.down ? (count_value == COUNT_ZERO) : (count_value == COUNT_MAX);
				period_end = 1'b1;
			end
			MODE_CTC, MODE_FPWM: begin
				ovf_cond = (count_value == COUNT_MAX);
				if (count_value >= top_act) begin
					step_count = COUNT_ZERO;
					period_end = 1'b1;
				end else begin
					step_count = f_step(count_value, 1'b0);
				end
			end
			MODE_PFC: begin
				if (!dir_down) begin
					if (count_value >= top_act && count_value != COUNT_ZERO) begin
						step_dir = 1'b1;
						step_count = f_step(count_value, 1'b1);
					end else if (count_value >= top_act) begin
						period_end = 1'b1;
					end else begin
						step_count = f_step(count_value, 1'b0);
					end
				end else if (count_value == COUNT_ZERO) begin
					step_dir = 1'b0;
					period_end = 1'b1;
					step_count = (top_act == COUNT_ZERO) ? COUNT_ZERO : f_step(count_value, 1'b0);
				end else begin
					step_count = f_step(count_value, 1'b1);
				end
			end
		endcase
	end

	// Pin reset beats a bus load, which beats a tick
	wire [CNT_W-1:0] next_count = pin_clear ? COUNT_ZERO :
		(wr_count ? pwdata[CNT_W-1:0] : (tick ? step_count : count_value));
	wire next_dir = (pin_clear | (ctrl_act.mode != MODE_PFC)) ? 1'b0 : (tick ? step_dir : dir_down);

	// Shadowed period and compare change only at period end, on pin reset or while disabled: no runt pulses
	wire load_shadow = pin_clear | ~ctrl_act.enable | (tick & period_end);
	wire [CNT_W-1:0] next_top_act = load_shadow ? top_src : top_act;
	wire [CNT_W-1:0] next_cmp_act = load_shadow ? cmp_src : cmp_act;

	// Compare and waveform
	wire cmp_match = (count_value == cmp_act);
	wire cmp_evt = tick & cmp_match;
	wire ovf_evt = tick & ovf_cond;
	wire pwm_mode = (ctrl_act.mode == MODE_FPWM) | (ctrl_act.mode == MODE_PFC);
	wire pwm_level = (count_value < cmp_act) ^ ctrl_act.invert;
	wire next_wave = pin_clear ? ctrl_act.invert :
		(pwm_mode ? pwm_level : (compare_wave_out ^ cmp_evt));

	// Capture: time stamp only in non-PWM modes with the bus in use
	wire cap_allowed = ctrl_act.cap_en & ~sa_level & ~pwm_mode;
	wire cap_set = cap_allowed & cap_rise;
	wire [CNT_W-1:0] next_capture = cap_set ? count_value : capture_holding_reg;

	// Sticky status; a new event wins over a clear in the same cycle
	wire [IRQ_W-1:0] irq_set = {cap_set, cmp_evt, ovf_evt};
	wire [IRQ_W-1:0] irq_clr = (wr_clr ? pwdata[IRQ_W-1:0] : IRQ_NONE) | {IRQ_W{pin_clear}};
	wire [IRQ_W-1:0] next_status = (irq_status & ~irq_clr) | irq_set;
	wire [IRQ_W-1:0] irq_gate = sa_level ? IRQ_OVF_ONLY : irq_en;
	wire next_irq = |(irq_status & irq_gate);

	// Bus slave: registered read data gives one access cycle per transfer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~addr_hit;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RST;
			prescale_reg <= PRESCALE_RST;
			top_reg <= TOP_RST;
			cmp_reg <= CMP_RST;
			irq_en <= IRQ_EN_RST;
			reset_pin_enable_bit <= RSTEN_PRE;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= htc_ctrl_t'(pwdata[CTRL_W-1:0]);
			end
			if (wr_psc) begin
				prescale_reg <= pwdata[CNT_W-1:0];
			end
			if (wr_top) begin
				top_reg <= pwdata[CNT_W-1:0];
			end
			if (wr_cmp) begin
				cmp_reg <= pwdata[CNT_W-1:0];
			end
			if (wr_en) begin
				irq_en <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// Timer core
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count_value <= COUNT_ZERO;
			dir_down <= 1'b0;
			psc_cnt <= COUNT_ZERO;
			top_act <= TOP_RST;
			cmp_act <= CMP_RST;
			capture_holding_reg <= COUNT_ZERO;
			compare_wave_out <= 1'b0;
		end else begin
			count_value <= next_count;
			dir_down <= next_dir;
			psc_cnt <= next_psc;
			top_act <= next_top_act;
			cmp_act <= next_cmp_act;
			capture_holding_reg <= next_capture;
			compare_wave_out <= next_wave;
		end
	end

	// Both interrupt lines are levels; wake-up is registered from the same status and gate as timer_irq_out
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irq_status <= IRQ_NONE;
			timer_irq_out <= 1'b0;
			wake_irq_out <= 1'b0;
		end else begin
			irq_status <= next_status;
			timer_irq_out <= next_irq;
			wake_irq_out <= next_irq;
		end
	end

endmodule : htc_timer

// [tb/htc_apb_master.sv]
/*
 Bus partner for htc_timer: the core-side master, one APB transfer per xfer call.
 Assumes a free-running mclk; waits on pready for as long as the slave takes.
*/
`timescale 1ns/100ps
module htc_apb_master
	import htc_pkg::*;
(
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel <= 1'h0;
		penable <= 1'h0;
		pwrite <= 1'h0;
		paddr <= 8'h0;
		pwdata <= 32'h0;
	end

	// Request held whole until ready is sampled high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
			@(posedge mclk);
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
endmodule : htc_apb_master

// [tb/htc_timer_assertions.sv]
/*
 Port checker for htc_timer: bus handshake, error answers, irq pins.
 Assumes the single mclk domain; bound to every htc_timer below.
*/
`timescale 1ns/100ps
module htc_timer_assertions
	import htc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer_clock_in,
	input wire logic timer_reset_low_input,
	input wire logic capture_trigger_in,
	input wire logic standalone_mode,
	input wire logic timer_irq_out,
	input wire logic wake_irq_out,
	input wire logic compare_wave_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	wire setup = psel && !penable;
	wire rd_setup = setup && !pwrite;
	// Unaligned offsets left out: their answer is not pinned down
	wire mapped = paddr <= ADDR_IRQ_CLEAR && paddr[1:0] == 2'h0;

	AST_READY_NEXT: assert property (setup |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |-> $past(setup) ##1 !pready)
		else $error("ready not a single access cycle");
	AST_ERR_UNMAPPED: assert property (setup && paddr > ADDR_IRQ_CLEAR |=> pslverr && pready)
		else $error("unmapped access without error");
	AST_ERR_MAPPED: assert property (setup && mapped |=> !pslverr)
		else $error("error on mapped access");
	AST_ERR_READ_ZERO: assert property (rd_setup && paddr > ADDR_IRQ_CLEAR |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RSTEN_ONE: assert property (rd_setup && paddr == ADDR_CTRL |=> prdata[CTRL_RSTEN_BIT])
		else $error("reset pin enable reads zero");
	AST_CLEAR_READS_ZERO: assert property (rd_setup && paddr == ADDR_IRQ_CLEAR |=> prdata == 32'h0)
		else $error("clear register reads nonzero");
	AST_WAKE_SAME: assert property (wake_irq_out == timer_irq_out)
		else $error("wake irq differs from irq");
	AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !pready && !timer_irq_out && !compare_wave_out)
		else $error("outputs active after reset");

	cover property (setup && pwrite);
	cover property (pslverr);
	cover property ($rose(timer_irq_out));
endmodule : htc_timer_assertions

bind htc_timer htc_timer_assertions htc_timer_assertions_i (.mclk, .sys_rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_clock_in, .timer_reset_low_input,
	.capture_trigger_in, .standalone_mode, .timer_irq_out, .wake_irq_out, .compare_wave_out);

// [tb/tb_top.sv]
/*
 Bench for htc_timer: register table loop, then counting, irq, pin reset,
 capture, PWM and stand-alone cases. Assumes the bus partner and bound checker.
*/
`timescale 1ns/100ps
module tb_top import htc_pkg::*; ;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} htc_row_t;
	logic mclk = 1'h0;
	logic sys_rst = 1'h1;
	logic timer_clock_in = 1'h0;
	logic timer_reset_low_input = 1'h1;
	logic capture_trigger_in = 1'h0;
	logic standalone_mode = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, timer_irq_out, wake_irq_out, compare_wave_out, e;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q;
	int err_total = 0;
	int total_checks = 0;
	int hi;
	htc_row_t rows [14] = '{
		'{1'h0, ADDR_CTRL, 32'h0, 32'h100, 1'h0},
		'{1'h0, ADDR_TOP, 32'h0, 32'hffff, 1'h0},
		'{1'h0, ADDR_CMP, 32'h0, 32'h0, 1'h0},
		'{1'h0, ADDR_IRQ_ENABLE, 32'h0, 32'h0, 1'h0},
		'{1'h1, ADDR_IRQ_STATUS, 32'h7, 32'h0, 1'h0},
		'{1'h0, ADDR_IRQ_STATUS, 32'h0, 32'h0, 1'h0},
		'{1'h1, ADDR_PRESCALE, 32'h2, 32'h0, 1'h0},
		'{1'h0, ADDR_PRESCALE, 32'h0, 32'h2, 1'h0},
		'{1'h1, 8'h40, 32'h1, 32'h0, 1'h1},
		'{1'h0, 8'h40, 32'h0, 32'h0, 1'h1},
		'{1'h0, ADDR_IRQ_CLEAR, 32'h0, 32'h0, 1'h0},
		'{1'h1, ADDR_COUNT, 32'h7, 32'h0, 1'h0},
		'{1'h1, ADDR_CTRL, 32'h1d, 32'h0, 1'h0},
		'{1'h0, ADDR_COUNT, 32'h0, 32'h7, 1'h0}};

	initial forever #20 mclk = ~mclk;

	htc_timer htc_timer_i (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .timer_clock_in, .timer_reset_low_input, .capture_trigger_in, .standalone_mode,
		.timer_irq_out, .wake_irq_out, .compare_wave_out);
	htc_apb_master htc_apb_master_i (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task close_out;
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task wr(input logic [7:0] a, input logic [31:0] d);
		htc_apb_master_i.xfer(1'h1, a, d, q, e);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		htc_apb_master_i.xfer(1'h0, a, 32'h0, q, e);
		chk(q, exp);
	endtask : rd
	// Pulse wide enough for the pin synchroniser
	task pulse;
		@(posedge mclk);
		capture_trigger_in <= 1'h1;
		cyc(4);
		capture_trigger_in <= 1'h0;
		cyc(8);
	endtask : pulse
	// Each level held four cycles so the synchroniser sees it
	task pin_clk(input int n);
		repeat (n) begin
			@(posedge mclk);
			timer_clock_in <= 1'h1;
			cyc(4);
			timer_clock_in <= 1'h0;
			cyc(3);
		end
		cyc(4);
	endtask : pin_clk
	task highs(input logic [31:0] exp);
		hi = 0;
		repeat (100) begin
			@(posedge mclk);
			hi += int'(compare_wave_out);
		end
		chk(32'(hi), exp);
	endtask : highs

	initial begin
		#200000;
		err_total++;
		close_out();
	end

	initial begin
		cyc(10);
		sys_rst <= 1'h0;
		foreach (rows[i]) begin
			htc_apb_master_i.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
			chk(q, rows[i].q);
			chk(32'(e), 32'(rows[i].e));
		end
		wr(ADDR_CTRL, 32'h11);
		cyc(300);
		wr(ADDR_CTRL, 32'h1);
		htc_apb_master_i.xfer(1'h0, ADDR_COUNT, 32'h0, q, e);
		chk(32'(q >= 32'h68 && q <= 32'h70), 32'h1);
		wr(ADDR_PRESCALE, 32'h0);
		wr(ADDR_COUNT, 32'hfff0);
		wr(ADDR_IRQ_ENABLE, 32'h1);
		wr(ADDR_CTRL, 32'h11);
		cyc(40);
		chk(32'(timer_irq_out), 32'h1);
		chk(32'(wake_irq_out), 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h3);
		wr(ADDR_IRQ_ENABLE, 32'h0);
		cyc(2);
		chk(32'(timer_irq_out), 32'h0);
		wr(ADDR_IRQ_ENABLE, 32'h2);
		cyc(2);
		chk(32'(timer_irq_out), 32'h1);
		wr(ADDR_IRQ_CLEAR, 32'h2);
		cyc(2);
		chk(32'(timer_irq_out), 32'h0);
		rd(ADDR_IRQ_STATUS, 32'h1);
		@(posedge mclk);
		timer_reset_low_input <= 1'h0;
		cyc(8);
		timer_reset_low_input <= 1'h1;
		htc_apb_master_i.xfer(1'h0, ADDR_COUNT, 32'h0, q, e);
		chk(32'(q < 32'h14), 32'h1);
		wr(ADDR_CTRL, 32'h21);
		wr(ADDR_COUNT, 32'h1234);
		wr(ADDR_IRQ_CLEAR, 32'h7);
		pulse();
		rd(ADDR_CAPTURE, 32'h1234);
		rd(ADDR_IRQ_STATUS, 32'h4);
		// PWM mode must not capture
		wr(ADDR_CTRL, 32'h22);
		wr(ADDR_COUNT, 32'h4321);
		pulse();
		rd(ADDR_CAPTURE, 32'h1234);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_TOP, 32'h9);
		wr(ADDR_CMP, 32'h3);
		wr(ADDR_CTRL, 32'h12);
		cyc(30);
		highs(32'h1e);
		wr(ADDR_TOP, 32'h4);
		wr(ADDR_CMP, 32'h2);
		cyc(30);
		highs(32'h28);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_TOP, 32'hffff);
		wr(ADDR_PRESCALE, 32'h1);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL, 32'h15);
		pin_clk(6);
		rd(ADDR_COUNT, 32'h3);
		wr(ADDR_CTRL, 32'h19);
		pin_clk(4);
		rd(ADDR_COUNT, 32'h5);
		wr(ADDR_PRESCALE, 32'h0);
		wr(ADDR_IRQ_CLEAR, 32'h7);
		wr(ADDR_IRQ_ENABLE, 32'h1);
		wr(ADDR_CTRL, 32'h90);
		chk(32'(timer_irq_out), 32'h0);
		cyc(10);
		chk(32'(timer_irq_out), 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_TOP, 32'h5);
		wr(ADDR_CMP, 32'h2);
		wr(ADDR_CTRL, 32'h53);
		cyc(30);
		highs(32'h46);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQ_ENABLE, 32'h0);
		wr(ADDR_IRQ_CLEAR, 32'h7);
		wr(ADDR_COUNT, 32'hffe0);
		@(posedge mclk);
		standalone_mode <= 1'h1;
		cyc(6);
		rd(ADDR_CTRL, 32'h110);
		wr(ADDR_TOP, 32'h7);
		rd(ADDR_TOP, 32'hffff);
		cyc(40);
		chk(32'(timer_irq_out), 32'h1);
		@(posedge mclk);
		standalone_mode <= 1'h0;
		cyc(6);
		rd(ADDR_TOP, 32'h5);
		close_out();
	end
endmodule : tb_top
